// ---- inc/qei_pkg.sv ----
// constants of the incremental encoder interface: register indices, field
// positions, reset values and widths.
// assumes a 32-bit apb slave whose byte address is four times the index.
package qei_pkg;
    localparam int POS_W = 24;
    localparam int DIV_W = 8;
    localparam int LIM_W = 12;
    localparam int CTL_W = 7;
    localparam int EVT_W = 3;
    localparam int ADDR_W = 8;

    // register indices; byte address is index * 4
    localparam logic [5:0] IDX_CONTROL   = 6'h10;
    localparam logic [5:0] IDX_PORT_LVL  = 6'h11;
    localparam logic [5:0] IDX_POSITION  = 6'h14;
    localparam logic [5:0] IDX_LATCHED   = 6'h18;
    localparam logic [5:0] IDX_DIV_COUNT = 6'h1C;
    localparam logic [5:0] IDX_DIV_RATIO = 6'h1D;
    localparam logic [5:0] IDX_DEV_LIMIT = 6'h1E;
    localparam logic [5:0] IDX_IRQ_STAT  = 6'h20;
    localparam logic [5:0] IDX_IRQ_EN    = 6'h21;
    localparam logic [5:0] IDX_IRQ_CLR   = 6'h22;

    // control field positions
    localparam int CB_INDEX_LEVEL   = 0;
    localparam int CB_CLEAR_ON_IDX  = 1;
    localparam int CB_LATCH_ON_IDX  = 2;
    localparam int CB_LATCH_NOW     = 3;
    localparam int CB_LOAD_RAMP     = 4;
    localparam int CB_LATCH_SNAP    = 5;
    localparam int CB_DIR_SELECT    = 6;

    // port level field positions
    localparam int PB_INDEX   = 0;
    localparam int PB_PHASE_B = 1;
    localparam int PB_PHASE_A = 2;

    // interrupt event positions
    localparam int EV_DEVIATION = 0;
    localparam int EV_INDEX     = 1;
    localparam int EV_LATCH     = 2;

    // reset values
    localparam logic [CTL_W-1:0] RST_CONTROL = 7'h00;
    localparam logic [POS_W-1:0] RST_POS     = 24'h000000;
    localparam logic [DIV_W-1:0] RST_DIV     = 8'h00;
    localparam logic [LIM_W-1:0] RST_LIMIT   = 12'h000;
    localparam logic [EVT_W-1:0] RST_EVT     = 3'h0;
endpackage : qei_pkg

// ---- rtl/qei_encoder_if.sv ----
// incremental encoder interface: quadrature decode, position counter,
// latch, pre-divider, deviation monitor and step/direction output.
// assumes encoder pins are asynchronous and ramp position / snapshot strobe
// come from logic on pclk.
// What this block does
// - decode phase a, phase b and index into a shaft position register
// - control bit 0 picks the active level of the index input
// - with control bit 1 set, an index event clears the position
// - with control bit 2 set, an index event latches the position
// - control bit 3 latches the position at once and clears itself
// - control bit 4 loads position from the ramp and clears itself
// - with control bit 5 set, the snapshot strobe latches the position
// - control bit 6 selects which phase leading counts positive
// - read-only port register shows index, phase b, phase a levels
// - the 24-bit position counter is readable and writable
// - the 24-bit latched register holds its value until the next latch
// - 8-bit pre-divider counts changes, 8-bit ratio sets its maximum
// - position minus ramp beyond the 12-bit limit raises an interrupt
// - decoded movement is given out as step pulse and direction
`timescale 1ns/1ps
module qei_encoder_if (
    input  wire logic        pclk,           // system clock, 20 mhz
    input  wire logic        presetn,        // async reset, active low
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb access phase
    input  wire logic        pwrite,         // apb write
    input  wire logic [7:0]  paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic      [31:0] prdata,         // apb read data
    output logic             pready,         // apb ready
    output logic             pslverr,        // apb error, unmapped address
    input  wire logic        quad_phase_a,   // encoder phase a pin
    input  wire logic        quad_phase_b,   // encoder phase b pin
    input  wire logic        index_pulse,    // encoder index pin
    input  wire logic [23:0] ramp_current_position, // ramp position
    input  wire logic        snapshot_strobe, // ramp snapshot pulse
    output logic             step_pulse,     // one pulse per counted step
    output logic             step_dir,       // 1 = positive direction
    output logic             irq             // level interrupt
);
    typedef struct packed {
        logic [qei_pkg::CTL_W-1:0] ctrl;
        logic                      a_s1;
        logic                      a_s2;
        logic                      a_q;
        logic                      b_s1;
        logic                      b_s2;
        logic                      b_q;
        logic                      n_s1;
        logic                      n_s2;
        logic                      idx_q;
        logic [qei_pkg::POS_W-1:0] pos;
        logic [qei_pkg::POS_W-1:0] hold;
        logic [qei_pkg::DIV_W-1:0] div_cnt;
        logic [qei_pkg::DIV_W-1:0] ratio;
        logic [qei_pkg::LIM_W-1:0] limit;
        logic [qei_pkg::EVT_W-1:0] stat;
        logic [qei_pkg::EVT_W-1:0] en;
        logic                      irq;
        logic                      step;
        logic                      dir;
        logic                      pready;
        logic                      pslverr;
        logic [31:0]               prdata;
    } qei_state_s;

    qei_state_s st_ff;
    qei_state_s nxt_st;

    logic [5:0]  reg_idx;
    logic        addr_ok;
    logic        setup;
    logic        wr;
    logic        chg;
    logic        both_chg;
    logic        up;
    logic        adv;
    logic        idx_act;
    logic        idx_evt;
    logic        latch_evt;
    logic [24:0] diff;
    logic [24:0] mag;
    logic        exceed;
    logic [qei_pkg::EVT_W-1:0] evt;

    assign reg_idx = paddr[7:2];
    assign addr_ok = (paddr[1:0] == 2'h0) &&
                     (reg_idx == qei_pkg::IDX_CONTROL   ||
                      reg_idx == qei_pkg::IDX_PORT_LVL  ||
                      reg_idx == qei_pkg::IDX_POSITION  ||
                      reg_idx == qei_pkg::IDX_LATCHED   ||
                      reg_idx == qei_pkg::IDX_DIV_COUNT ||
                      reg_idx == qei_pkg::IDX_DIV_RATIO ||
                      reg_idx == qei_pkg::IDX_DEV_LIMIT ||
                      reg_idx == qei_pkg::IDX_IRQ_STAT  ||
                      reg_idx == qei_pkg::IDX_IRQ_EN    ||
                      reg_idx == qei_pkg::IDX_IRQ_CLR);
    assign setup = psel && !penable;
    assign wr    = psel && penable && st_ff.pready && pwrite && addr_ok;

    // decode works on the second sync stage and its delayed copy only
    assign chg      = (st_ff.a_s2 ^ st_ff.a_q) | (st_ff.b_s2 ^ st_ff.b_q);
    // a double change is an illegal jump; it is dropped, not guessed
    assign both_chg = (st_ff.a_s2 ^ st_ff.a_q) & (st_ff.b_s2 ^ st_ff.b_q);
    assign up       = (st_ff.a_s2 ^ st_ff.b_q) ^
                      ~st_ff.ctrl[qei_pkg::CB_DIR_SELECT];
    assign adv      = chg && !both_chg &&
                      (st_ff.div_cnt == st_ff.ratio);

    assign idx_act = (st_ff.n_s2 ==
                      st_ff.ctrl[qei_pkg::CB_INDEX_LEVEL]);
    assign idx_evt = idx_act && !st_ff.idx_q;

    assign latch_evt =
        (idx_evt && st_ff.ctrl[qei_pkg::CB_LATCH_ON_IDX]) ||
        st_ff.ctrl[qei_pkg::CB_LATCH_NOW] ||
        (st_ff.ctrl[qei_pkg::CB_LATCH_SNAP] && snapshot_strobe);

    assign diff   = {st_ff.pos[23], st_ff.pos} -
                    {ramp_current_position[23], ramp_current_position};
    assign mag    = diff[24] ? 25'(-diff) : diff;
    assign exceed = mag > {13'h0000, st_ff.limit};

    always_comb begin
        evt = '0;
        evt[qei_pkg::EV_DEVIATION] = exceed;
        evt[qei_pkg::EV_INDEX]     = idx_evt;
        evt[qei_pkg::EV_LATCH]     = latch_evt;
    end

    always_comb begin
        nxt_st = st_ff;

        // pins pass two flops before anything reads them
        nxt_st.a_s1  = quad_phase_a;
        nxt_st.a_s2  = st_ff.a_s1;
        nxt_st.a_q   = st_ff.a_s2;
        nxt_st.b_s1  = quad_phase_b;
        nxt_st.b_s2  = st_ff.b_s1;
        nxt_st.b_q   = st_ff.b_s2;
        nxt_st.n_s1  = index_pulse;
        nxt_st.n_s2  = st_ff.n_s1;
        nxt_st.idx_q = idx_act;

        // pre-divider and position counting
        if (chg && !both_chg) begin
            if (adv) begin
                nxt_st.div_cnt = '0;
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
            end
        end
        if (adv) begin
            nxt_st.pos = up ? st_ff.pos + 24'h000001
                            : st_ff.pos - 24'h000001;
        end
        if (idx_evt && st_ff.ctrl[qei_pkg::CB_CLEAR_ON_IDX]) begin
            nxt_st.pos = '0;
        end
        if (st_ff.ctrl[qei_pkg::CB_LOAD_RAMP]) begin
            nxt_st.pos = ramp_current_position;
        end

        // step and direction follow every counted step
        nxt_st.step = adv;
        if (adv) begin
            nxt_st.dir = up;
        end

        if (latch_evt) begin
            nxt_st.hold = st_ff.pos;
        end

        // one-shot commands drop back after a single cycle
        nxt_st.ctrl[qei_pkg::CB_LATCH_NOW] = 1'b0;
        nxt_st.ctrl[qei_pkg::CB_LOAD_RAMP] = 1'b0;

        // register writes take effect at the access edge
        if (wr) begin
            case (reg_idx)
                qei_pkg::IDX_CONTROL: begin
                    nxt_st.ctrl = pwdata[qei_pkg::CTL_W-1:0];
                end
                qei_pkg::IDX_POSITION: begin
                    nxt_st.pos = pwdata[23:0];
                end
                qei_pkg::IDX_DIV_COUNT: begin
                    nxt_st.div_cnt = pwdata[7:0];
                end
                qei_pkg::IDX_DIV_RATIO: begin
                    nxt_st.ratio = pwdata[7:0];
                end
                qei_pkg::IDX_DEV_LIMIT: begin
                    nxt_st.limit = pwdata[11:0];
                end
                qei_pkg::IDX_IRQ_EN: begin
                    nxt_st.en = pwdata[qei_pkg::EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky events; a new event beats a clear in the same cycle
        if (wr && reg_idx == qei_pkg::IDX_IRQ_CLR) begin
            nxt_st.stat = (st_ff.stat & ~pwdata[qei_pkg::EVT_W-1:0]) | evt;
        end else begin
            nxt_st.stat = st_ff.stat | evt;
        end
        nxt_st.irq = |(nxt_st.stat & nxt_st.en);

        // apb: one wait-free access cycle, data ready from the setup cycle
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup && !addr_ok;
        if (setup) begin
            nxt_st.prdata = '0;
            if (addr_ok && !pwrite) begin
                case (reg_idx)
                    qei_pkg::IDX_CONTROL: begin
                        nxt_st.prdata[qei_pkg::CTL_W-1:0] = st_ff.ctrl;
                    end
                    qei_pkg::IDX_PORT_LVL: begin
                        nxt_st.prdata[qei_pkg::PB_INDEX]   = st_ff.n_s2;
                        nxt_st.prdata[qei_pkg::PB_PHASE_B] = st_ff.b_s2;
                        nxt_st.prdata[qei_pkg::PB_PHASE_A] =
                            st_ff.a_s2;
                    end
                    qei_pkg::IDX_POSITION: begin
                        nxt_st.prdata[23:0] = st_ff.pos;
                    end
                    qei_pkg::IDX_LATCHED: begin
                        nxt_st.prdata[23:0] = st_ff.hold;
                    end
                    qei_pkg::IDX_DIV_COUNT: begin
                        nxt_st.prdata[7:0] = st_ff.div_cnt;
                    end
                    qei_pkg::IDX_DIV_RATIO: begin
                        nxt_st.prdata[7:0] = st_ff.ratio;
                    end
                    qei_pkg::IDX_DEV_LIMIT: begin
                        nxt_st.prdata[11:0] = st_ff.limit;
                    end
                    qei_pkg::IDX_IRQ_STAT: begin
                        nxt_st.prdata[qei_pkg::EVT_W-1:0] = st_ff.stat;
                    end
                    qei_pkg::IDX_IRQ_EN: begin
                        nxt_st.prdata[qei_pkg::EVT_W-1:0] = st_ff.en;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff         <= '0;
            // edge detector starts as already active so a quiet pin
            // after reset is not mistaken for an index event
            st_ff.idx_q   <= 1'b1;
            st_ff.ctrl    <= qei_pkg::RST_CONTROL;
            st_ff.pos     <= qei_pkg::RST_POS;
            st_ff.hold    <= qei_pkg::RST_POS;
            st_ff.div_cnt <= qei_pkg::RST_DIV;
            st_ff.ratio   <= qei_pkg::RST_DIV;
            st_ff.limit   <= qei_pkg::RST_LIMIT;
            st_ff.stat    <= qei_pkg::RST_EVT;
            st_ff.en      <= qei_pkg::RST_EVT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata     = st_ff.prdata;
    assign pready     = st_ff.pready;
    assign pslverr    = st_ff.pslverr;
    assign step_pulse = st_ff.step;
    assign step_dir   = st_ff.dir;
    assign irq        = st_ff.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_ready_a: assert property (setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    port_levels_a: assert property (
        setup && !pwrite && reg_idx == qei_pkg::IDX_PORT_LVL &&
        paddr[1:0] == 2'h0
        |=> prdata == {29'h0, $past(st_ff.a_s2), $past(st_ff.b_s2),
                       $past(st_ff.n_s2)})
        else $error("port level read wrong");
    latch_now_a: assert property (
        st_ff.ctrl[qei_pkg::CB_LATCH_NOW]
        |=> st_ff.hold == $past(st_ff.pos) &&
            !st_ff.ctrl[qei_pkg::CB_LATCH_NOW])
        else $error("immediate latch failed");
    load_ramp_a: assert property (
        st_ff.ctrl[qei_pkg::CB_LOAD_RAMP] &&
        !(wr && reg_idx == qei_pkg::IDX_POSITION)
        |=> st_ff.pos == $past(ramp_current_position))
        else $error("ramp load failed");
    clear_index_a: assert property (
        idx_evt && st_ff.ctrl[qei_pkg::CB_CLEAR_ON_IDX] &&
        !st_ff.ctrl[qei_pkg::CB_LOAD_RAMP] && !wr
        |=> st_ff.pos == 24'h000000)
        else $error("index clear failed");
    hold_stable_a: assert property (!latch_evt |=> $stable(st_ff.hold))
        else $error("latched value changed without latch");
    div_wrap_a: assert property (
        adv && !wr && !st_ff.ctrl[qei_pkg::CB_LOAD_RAMP] &&
        !(idx_evt && st_ff.ctrl[qei_pkg::CB_CLEAR_ON_IDX])
        |=> st_ff.div_cnt == 8'h00 && step_pulse &&
        st_ff.pos == $past(st_ff.pos) + ($past(up) ? 24'h000001
                                                   : 24'hFFFFFF))
        else $error("divider wrap or step wrong");
    step_dir_a: assert property (adv |=> step_dir == $past(up))
        else $error("direction output wrong");
    dev_irq_a: assert property (
        exceed && st_ff.en[qei_pkg::EV_DEVIATION] &&
        !(wr && reg_idx == qei_pkg::IDX_IRQ_EN)
        |=> st_ff.stat[qei_pkg::EV_DEVIATION] && irq)
        else $error("deviation interrupt missing");
    irq_level_a: assert property (irq == |(st_ff.stat & st_ff.en))
        else $error("interrupt level mismatch");

    // divider, latch, write, status, step/direction and apb paths
    div_count_a: assert property (
        chg && !both_chg && !adv && !wr
        |=> st_ff.div_cnt == $past(st_ff.div_cnt) + 8'h01)
        else $error("divider count step wrong");
    ratio_write_a: assert property (
        wr && reg_idx == qei_pkg::IDX_DIV_RATIO
        |=> st_ff.ratio == $past(pwdata[7:0]))
        else $error("ratio write lost");
    idx_latch_a: assert property (
        idx_evt && st_ff.ctrl[qei_pkg::CB_LATCH_ON_IDX]
        |=> st_ff.hold == $past(st_ff.pos))
        else $error("index latch failed");
    snap_latch_a: assert property (
        st_ff.ctrl[qei_pkg::CB_LATCH_SNAP] && snapshot_strobe
        |=> st_ff.hold == $past(st_ff.pos))
        else $error("snapshot latch failed");
    pos_write_a: assert property (
        wr && reg_idx == qei_pkg::IDX_POSITION
        |=> st_ff.pos == $past(pwdata[23:0]))
        else $error("position write lost");
    stat_sticky_a: assert property (
        st_ff.stat[qei_pkg::EV_DEVIATION] &&
        !(wr && reg_idx == qei_pkg::IDX_IRQ_CLR)
        |=> st_ff.stat[qei_pkg::EV_DEVIATION])
        else $error("deviation status lost without clear");
    irq_clear_a: assert property (
        wr && reg_idx == qei_pkg::IDX_IRQ_CLR &&
        pwdata[qei_pkg::EV_DEVIATION] && !exceed
        |=> !st_ff.stat[qei_pkg::EV_DEVIATION])
        else $error("deviation status clear ignored");
    step_pulse_a: assert property (!adv |=> !step_pulse)
        else $error("step pulse without a counted step");
    dir_hold_a: assert property (!adv |=> $stable(step_dir))
        else $error("direction moved without a step");
    slverr_a: assert property (setup && !addr_ok |=> pslverr && pready)
        else $error("unmapped access not flagged");
    prdata_hold_a: assert property (!setup |=> $stable(prdata))
        else $error("read data moved outside a setup");

    idx_clear_c: cover property (
        idx_evt && st_ff.ctrl[qei_pkg::CB_CLEAR_ON_IDX]);
    snap_latch_c: cover property (
        st_ff.ctrl[qei_pkg::CB_LATCH_SNAP] && snapshot_strobe);
    div_wrap_c: cover property (adv && st_ff.ratio != 8'h00);
    irq_c: cover property (!irq ##1 irq);
    load_ramp_c: cover property (st_ff.ctrl[qei_pkg::CB_LOAD_RAMP]);
endmodule : qei_encoder_if

// ---- tb/qei_quad_model.sv ----
// behavioural quadrature encoder: one gray step per request.
// assumes requests come on pclk; each state is held at least five cycles so that
// the decoder's one-cycle minimum dwell is always met.
`timescale 1ns/1ps
module qei_quad_model (
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset, active low
    input  wire logic step_req, // take one step when not busy
    input  wire logic step_fwd, // 1 = phase a leads phase b
    output logic      phase_a,  // encoder phase a
    output logic      phase_b,  // encoder phase b
    output logic      busy      // state still dwelling
);
    logic [1:0] st_ff;
    logic [2:0] hold_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff   <= 2'h0;
            hold_ff <= 3'h0;
        end else if (hold_ff != 3'h0) begin
            hold_ff <= hold_ff - 3'h1;
        end else if (step_req) begin
            st_ff   <= step_fwd ? st_ff + 2'h1 : st_ff - 2'h1;
            hold_ff <= 3'h4;
        end
    end

    // gray order 00,10,11,01: only one phase moves per step
    assign phase_a = st_ff[1] ^ st_ff[0];
    assign phase_b = st_ff[1];
    assign busy    = hold_ff != 3'h0;
endmodule : qei_quad_model

// ---- tb/qei_encoder_if_tb.sv ----
// self-checking bench of the incremental encoder interface.
// assumes the apb slave answers with pready and an encoder model in tb/.
`timescale 1ns/1ps
module qei_encoder_if_tb;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, phase_a, phase_b, enc_busy;
    logic        step_req = 1'h0;
    logic        step_fwd = 1'h1;
    logic        index_pulse = 1'h0;
    logic        snap = 1'h0;
    logic [23:0] ramp = 24'h0;
    logic        step_pulse, step_dir, irq;
    int          err_count = 0;
    int          check_count = 0;
    int          pulses = 0;

    always #25 pclk = ~pclk;
    always @(posedge pclk) if (step_pulse === 1'h1) pulses <= pulses + 1;

    qei_encoder_if DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .quad_phase_a(phase_a), .quad_phase_b(phase_b),
        .index_pulse(index_pulse), .ramp_current_position(ramp),
        .snapshot_strobe(snap), .step_pulse(step_pulse),
        .step_dir(step_dir), .irq(irq));
    qei_quad_model ENC (.pclk(pclk), .presetn(presetn), .step_req(step_req),
        .step_fwd(step_fwd), .phase_a(phase_a), .phase_b(phase_b),
        .busy(enc_busy));

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // one setup and one or more access cycles; released only after pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            err_count++;
            summarize();
        end
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(rd, e);
    endtask : rd_chk

    task automatic move(input int n, input logic fwd);
        int w;
        step_fwd <= fwd;
        for (int i = 0; i < n; i++) begin
            w = 0;
            do begin
                @(posedge pclk);
                w++;
            end while (enc_busy !== 1'h0 && w < 16);
            if (w >= 16) begin
                err_count++;
                summarize();
            end
            step_req <= 1'h1;
            @(posedge pclk);
            step_req <= 1'h0;
        end
        repeat (8) @(posedge pclk);
    endtask : move

    task automatic idx(input logic lvl);
        index_pulse <= lvl;
        repeat (6) @(posedge pclk);
    endtask : idx

    task automatic t_reset();
        logic [7:0] addrs [7] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h74,
                                  8'h78, 8'h80};
        foreach (addrs[i]) begin
            rd_chk(addrs[i], 32'h0);
        end
        apb(1'h0, 8'hFC, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask : t_reset

    task automatic t_port();
        idx(1'h1);
        move(2, 1'h1);
        rd_chk(8'h44, 32'h7);
        idx(1'h0);
        move(1, 1'h1);
        rd_chk(8'h44, 32'h2);
        $display("test port done");
    endtask : t_port

    task automatic t_dir();
        int p0;
        apb(1'h1, 8'h40, 32'h40);
        apb(1'h1, 8'h50, 32'h0);
        p0 = pulses;
        move(5, 1'h1);
        rd_chk(8'h50, 32'h5);
        check(pulses - p0, 32'h5);
        check({31'h0, step_dir}, 32'h1);
        apb(1'h1, 8'h40, 32'h0);
        move(6, 1'h1);
        rd_chk(8'h50, 32'hFFFFFF);
        check({31'h0, step_dir}, 32'h0);
        move(4, 1'h0);
        rd_chk(8'h50, 32'h3);
        $display("test direction done");
    endtask : t_dir

    task automatic t_div();
        apb(1'h1, 8'h40, 32'h40);
        apb(1'h1, 8'h50, 32'h0);
        apb(1'h1, 8'h74, 32'h3);
        rd_chk(8'h74, 32'h3);
        move(6, 1'h1);
        rd_chk(8'h50, 32'h1);
        rd_chk(8'h70, 32'h2);
        apb(1'h1, 8'h70, 32'h3);
        move(1, 1'h1);
        rd_chk(8'h50, 32'h2);
        rd_chk(8'h70, 32'h0);
        apb(1'h1, 8'h74, 32'h0);
        $display("test divider done");
    endtask : t_div

    task automatic t_idx();
        apb(1'h1, 8'h50, 32'h100);
        apb(1'h1, 8'h40, 32'h45);
        idx(1'h1);
        idx(1'h0);
        rd_chk(8'h60, 32'h100);
        apb(1'h1, 8'h50, 32'h200);
        apb(1'h1, 8'h60, 32'h5A5);
        rd_chk(8'h60, 32'h100);
        apb(1'h1, 8'h40, 32'h43);
        idx(1'h1);
        idx(1'h0);
        rd_chk(8'h50, 32'h0);
        idx(1'h1);
        apb(1'h1, 8'h40, 32'h04);
        apb(1'h1, 8'h50, 32'h300);
        rd_chk(8'h60, 32'h100);
        idx(1'h0);
        rd_chk(8'h60, 32'h300);
        $display("test index done");
    endtask : t_idx

    task automatic t_now();
        apb(1'h1, 8'h50, 32'h123456);
        apb(1'h1, 8'h40, 32'h08);
        rd_chk(8'h60, 32'h123456);
        rd_chk(8'h40, 32'h0);
        ramp <= 24'hABCDEF;
        apb(1'h1, 8'h40, 32'h10);
        rd_chk(8'h50, 32'hABCDEF);
        rd_chk(8'h40, 32'h0);
        apb(1'h1, 8'h40, 32'h20);
        apb(1'h1, 8'h50, 32'h654321);
        snap <= 1'h1;
        @(posedge pclk);
        snap <= 1'h0;
        repeat (3) @(posedge pclk);
        rd_chk(8'h60, 32'h654321);
        $display("test latch now done");
    endtask : t_now

    task automatic t_irq();
        apb(1'h1, 8'h40, 32'h0);
        apb(1'h1, 8'h78, 32'h010);
        ramp <= 24'h001010;
        apb(1'h1, 8'h50, 32'h001000);
        apb(1'h1, 8'h88, 32'h7);
        rd_chk(8'h80, 32'h0);
        ramp <= 24'h000FEF;
        repeat (3) @(posedge pclk);
        rd_chk(8'h80, 32'h1);
        apb(1'h1, 8'h84, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        ramp <= 24'h001000;
        apb(1'h1, 8'h88, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        $display("test deviation done");
    endtask : t_irq

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_port();
        t_dir();
        t_div();
        t_idx();
        t_now();
        t_irq();
        summarize();
    end
endmodule : qei_encoder_if_tb
